// *** rtl/sdram_cmd_params.svh ***
// timing counts and field positions for the sdram command and bank tracker
`ifndef SDRAM_CMD_PARAMS_SVH
`define SDRAM_CMD_PARAMS_SVH
`define CLOCK_PERIOD_NS      5
`define ROW_BITS             11
`define COL_BITS             8
`define BANK_COUNT           4
`define MASK_LANES           4
`define PRE_SEL_BIT          10
`define BURST_LEN_LSB        0
`define BURST_LEN_FULL       3'h7
`define BURST_LEN_ONE        3'h0
`endif

// *** rtl/sdram_cmd_pkg.sv ***
// types shared by the sdram command decoder and bank tracker
package sdram_cmd_pkg;
    // decoded command of one cycle
    typedef enum logic [3:0] {
        CMD_DESELECT   = 4'h0,
        CMD_NOP        = 4'h1,
        CMD_OPEN_ROW   = 4'h2,
        CMD_CLOSE_ONE  = 4'h3,
        CMD_CLOSE_ALL  = 4'h4,
        CMD_READ       = 4'h5,
        CMD_WRITE      = 4'h6,
        CMD_MODE_SET   = 4'h7,
        CMD_BURST_STOP = 4'h8,
        CMD_REFRESH    = 4'h9,
        CMD_SELF_ENTRY = 4'ha,
        CMD_CLK_HOLD   = 4'hb,
        CMD_PWR_ENTRY  = 4'hc,
        CMD_WAKE       = 4'hd
    } cmd_t;
    // command pins sampled at one edge
    typedef struct packed {
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic        cke;
        logic [1:0]  bank_select;
        logic [10:0] addr;
        logic [3:0]  byte_mask;
    } cmd_pins_t;
    // device power state, one-hot
    typedef enum logic [3:0] {
        PS_RUN  = 4'h1,
        PS_HOLD = 4'h2,
        PS_PDN  = 4'h4,
        PS_SELF = 4'h8
    } pstate_t;
    // write strobe delivered to the array
    typedef struct packed {
        logic        valid;
        logic [1:0]  bank;
        logic [10:0] row;
        logic [7:0]  col;
        logic [3:0]  lane_en;
    } wr_req_t;
endpackage

// *** rtl/sdram_command_bank_state.sv ***
// command decoder and per-bank state tracking of a four-bank sdram
//----------------------------------------------------------------------
// Summary of operation
// - sample all command pins on rising edge
// - decode using previous and current clock enable
// - activate encoding: cs ras low, cas we high
// - activate opens bank, latches eleven-bit row
// - four banks, each idle or active
// - writes after activate are unmasked by default
// - single precharge: we low, bit10 low
// - single precharge returns chosen bank idle
// - precharge all: bit10 high, bank ignored
// - precharge all idles every bank, accepted in any bank state while running
// - clock enable fall with a non-nop strobe other than refresh suspends
// - power-down entry and exit on nop/deselect
// - falling clock enable in burst means suspend, except with a refresh strobe
// - burst stop ends the current burst
// - read/write encoding, bit10 autoprecharge except with full-page burst length, column bits
// - mode set all low, only when idle
// - mask high blocks its byte lane
//----------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "sdram_cmd_params.svh"
module sdram_command_bank_state #(
    parameter int BANKS = `BANK_COUNT  // number of banks
) (
    // clock and reset
    input  wire logic                     clock,
    input  wire logic                     rst,
    // command bus from the memory controller
    input  wire sdram_cmd_pkg::cmd_pins_t pins,
    // decoded state
    output var  sdram_cmd_pkg::cmd_t      cmd_q,
    output var  logic [BANKS-1:0]         bank_active_q,
    output var  logic [43:0]              open_rows_q,
    output var  sdram_cmd_pkg::pstate_t   pstate_q,
    output var  logic                     burst_q,
    output var  logic [10:0]              mode_q,
    output var  sdram_cmd_pkg::wr_req_t   wr_q,
    output var  logic                     refresh_q
);
    import sdram_cmd_pkg::*;

    // idle bus assumed before the first sampled edge: deselect with
    // clock enable high, so no false clock enable fall follows reset
    localparam cmd_pins_t PINS_IDLE = '{cs_n: 1'b1, ras_n: 1'b1,
        cas_n: 1'b1, we_n: 1'b1, cke: 1'b1, bank_select: 2'h0,
        addr: 11'h000, byte_mask: 4'h0};

    // elaboration check: the row vector is sized for four banks
    if (BANKS != `BANK_COUNT) begin : g_bad_banks
        $error("only four banks are supported");
    end

    //------------------------------------------------------------------
    // input stage
    //------------------------------------------------------------------
    // pins come from the same clock domain as the controller, so a
    // single register captures them; no synchroniser is used
    cmd_pins_t pins_q;        // registered pins
    logic      cke_prev_q;    // clock enable of the previous cycle
    cmd_t      dec;           // decoded command

    // decode one command from a pin snapshot and the previous cke
    function automatic cmd_t decode(input cmd_pins_t p, input logic ckp);
        cmd_t c;
        c = CMD_DESELECT;
        if (!ckp) begin
            // low-to-high cke wakes, whatever the strobes say
            c = p.cke ? CMD_WAKE : CMD_DESELECT;
        end else if (!p.cke && (p.cs_n || (p.ras_n && p.cas_n && p.we_n))) begin
            c = CMD_PWR_ENTRY;
        end else if (!p.cke && !p.ras_n && !p.cas_n && p.we_n) begin
            c = CMD_SELF_ENTRY;
        end else if (!p.cke) begin
            c = CMD_CLK_HOLD;
        end else if (p.cs_n) begin
            c = CMD_DESELECT;
        end else begin
            case ({p.ras_n, p.cas_n, p.we_n})
                3'h3: c = CMD_OPEN_ROW;
                3'h2: c = p.addr[`PRE_SEL_BIT] ? CMD_CLOSE_ALL
                                               : CMD_CLOSE_ONE;
                3'h5: c = CMD_READ;
                3'h4: c = CMD_WRITE;
                3'h0: c = CMD_MODE_SET;
                3'h1: c = CMD_REFRESH;
                3'h6: c = CMD_BURST_STOP;
                default: c = CMD_NOP;
            endcase
        end
        return c;
    endfunction

    always_comb begin
        dec = decode(pins_q, cke_prev_q);
    end

    //------------------------------------------------------------------
    // bank, power and burst state
    //------------------------------------------------------------------
    logic [BANKS-1:0] bank_d;    // next bank state
    logic [43:0]      rows_d;    // next open rows
    pstate_t          ps_d;      // next power state
    logic             burst_d;   // next burst flag
    logic [8:0]       blen_q;    // remaining beats
    logic [8:0]       blen_d;
    logic [10:0]      mode_d;
    wr_req_t          wr_d;
    logic             ref_d;
    logic [8:0]       beats;     // burst length from mode register
    logic             all_idle;

    always_comb begin
        case (mode_q[2:0])
            3'h0:    beats = 9'h001;
            3'h1:    beats = 9'h002;
            3'h2:    beats = 9'h004;
            3'h3:    beats = 9'h008;
            default: beats = 9'h100;  // full page counts as one page
        endcase
        all_idle = (bank_active_q == '0);
    end

    always_comb begin
        bank_d  = bank_active_q;
        rows_d  = open_rows_q;
        ps_d    = pstate_q;
        burst_d = burst_q;
        blen_d  = blen_q;
        mode_d  = mode_q;
        wr_d    = '0;
        ref_d   = 1'b0;
        case (pstate_q)
            PS_RUN: begin
                // internal state only moves while running
                if (burst_q && blen_q != 9'h000 &&
                    mode_q[2:0] != `BURST_LEN_FULL) begin
                    blen_d = blen_q - 9'h001;
                    if (blen_q == 9'h001) burst_d = 1'b0;
                end
                case (dec)
                    CMD_OPEN_ROW: begin
                        if (!bank_active_q[pins_q.bank_select]) begin
                            bank_d[pins_q.bank_select] = 1'b1;
                            rows_d[pins_q.bank_select*11 +: 11] =
                                pins_q.addr;
                        end
                    end
                    CMD_CLOSE_ONE: begin
                        bank_d[pins_q.bank_select] = 1'b0;
                    end
                    CMD_CLOSE_ALL: begin
                        bank_d = '0;
                    end
                    CMD_READ, CMD_WRITE: begin
                        if (bank_active_q[pins_q.bank_select]) begin
                            burst_d = (beats != 9'h001);
                            blen_d  = beats - 9'h001;
                            if (dec == CMD_WRITE) begin
                                wr_d.valid = 1'b1;
                                wr_d.bank  = pins_q.bank_select;
                                wr_d.row   =
                                  open_rows_q[pins_q.bank_select*11 +: 11];
                                wr_d.col   = pins_q.addr[7:0];
                                // unmasked unless a mask is high
                                wr_d.lane_en = ~pins_q.byte_mask;
                            end
                            if (pins_q.addr[`PRE_SEL_BIT] &&
                                mode_q[2:0] != `BURST_LEN_FULL)
                                bank_d[pins_q.bank_select] = 1'b0;
                        end
                    end
                    CMD_BURST_STOP: begin
                        burst_d = 1'b0;
                        blen_d  = 9'h000;
                    end
                    CMD_MODE_SET: begin
                        if (all_idle) mode_d = pins_q.addr;
                    end
                    CMD_REFRESH: begin
                        ref_d = all_idle;
                    end
                    CMD_SELF_ENTRY: begin
                        if (all_idle) ps_d = PS_SELF;
                    end
                    CMD_PWR_ENTRY: begin
                        // a burst in flight turns this into a suspend
                        ps_d = burst_q ? PS_HOLD : PS_PDN;
                    end
                    CMD_CLK_HOLD: begin
                        ps_d = PS_HOLD;
                    end
                    default: begin
                        // deselect and nop change nothing
                    end
                endcase
            end
            PS_HOLD: begin
                if (dec == CMD_WAKE) ps_d = PS_RUN;
            end
            default: begin
                // power-down and self refresh need nop/deselect to exit
                if (dec == CMD_WAKE &&
                    (pins_q.cs_n || (pins_q.ras_n && pins_q.cas_n &&
                                     pins_q.we_n)))
                    ps_d = PS_RUN;
            end
        endcase
    end

    // registers: pins captured on the rising edge only
    always_ff @(posedge clock) begin
        if (rst) begin
            pins_q        <= PINS_IDLE;
            cke_prev_q    <= 1'b1;
            cmd_q         <= CMD_DESELECT;
            bank_active_q <= '0;
            open_rows_q   <= '0;
            pstate_q      <= PS_RUN;
            burst_q       <= 1'b0;
            blen_q        <= 9'h000;
            mode_q        <= 11'h000;
            wr_q          <= '0;
            refresh_q     <= 1'b0;
        end else begin
            pins_q        <= pins;
            cke_prev_q    <= pins_q.cke;
            cmd_q         <= dec;
            bank_active_q <= bank_d;
            open_rows_q   <= rows_d;
            pstate_q      <= ps_d;
            burst_q       <= burst_d;
            blen_q        <= blen_d;
            mode_q        <= mode_d;
            wr_q          <= wr_d;
            refresh_q     <= ref_d;
        end
    end

    //------------------------------------------------------------------
    // checks
    //------------------------------------------------------------------
    close_all_a: assert property (@(posedge clock) disable iff (rst)
        (pstate_q == PS_RUN && dec == CMD_CLOSE_ALL) |=> bank_active_q == '0)
        else $error("precharge all left a bank open");
    open_row_a: assert property (@(posedge clock) disable iff (rst)
        (pstate_q == PS_RUN && dec == CMD_OPEN_ROW &&
         !bank_active_q[pins_q.bank_select])
        |=> bank_active_q[$past(pins_q.bank_select)])
        else $error("activate did not open bank");
    close_one_a: assert property (@(posedge clock) disable iff (rst)
        (pstate_q == PS_RUN && dec == CMD_CLOSE_ONE)
        |=> !bank_active_q[$past(pins_q.bank_select)])
        else $error("precharge left bank open");
    hold_entry_a: assert property (@(posedge clock) disable iff (rst)
        (pstate_q == PS_RUN && dec == CMD_PWR_ENTRY && burst_q)
        |=> pstate_q == PS_HOLD)
        else $error("power-down entered during burst");
    wake_a: assert property (@(posedge clock) disable iff (rst)
        (pstate_q == PS_HOLD && dec == CMD_WAKE) |=> pstate_q == PS_RUN)
        else $error("suspend exit failed");
    frozen_a: assert property (@(posedge clock) disable iff (rst)
        (pstate_q != PS_RUN) |=> $stable(bank_active_q))
        else $error("bank state moved while frozen");
    stop_a: assert property (@(posedge clock) disable iff (rst)
        (pstate_q == PS_RUN && dec == CMD_BURST_STOP) |=> !burst_q)
        else $error("burst stop ignored");
    mask_a: assert property (@(posedge clock) disable iff (rst)
        (pstate_q == PS_RUN && dec == CMD_WRITE &&
         bank_active_q[pins_q.bank_select])
        |=> wr_q.valid && wr_q.lane_en == ~$past(pins_q.byte_mask))
        else $error("byte lanes wrong on write");
    deselect_a: assert property (@(posedge clock) disable iff (rst)
        (cke_prev_q && pins_q.cke && pins_q.cs_n) |-> dec == CMD_DESELECT)
        else $error("deselect decoded as command");
endmodule
`default_nettype wire

// *** test/sdram_ctrl_model.sv ***
// controller-side model that drives the sdram command pins
`timescale 1ns/10ps
`default_nettype none
module sdram_ctrl_model #(
    parameter int GAP = 2  // idle cycles the controller leaves after a command
) (
    // clock
    input  wire logic                     clock,
    // command pins toward the memory
    output var  sdram_cmd_pkg::cmd_pins_t pins
);
    import sdram_cmd_pkg::*;
    // power up deselected with clock enable high
    initial begin
        pins = {4'hf, 1'b1, 2'h0, 11'h0, 4'h0};
    end
    // one command at a falling edge, then nops holding clock enable;
    // the spacing keeps activate-to-access, same-bank and cross-bank
    // gaps and bounds the open time, all of which the memory trusts
    task automatic send(input logic [3:0] s, input logic k,
                        input logic [1:0] b, input logic [10:0] a,
                        input logic [3:0] m);
        int i;
        @(negedge clock);
        // strobe code is cs_n, ras_n, cas_n, we_n as the caller encodes it
        pins <= {s, k, b, a, m};
        for (i = 0; i < GAP; i++) begin
            @(negedge clock);
            // nop; stale lines are inverted so old values never linger
            pins <= {4'h7, k, ~b, ~a, ~m};
        end
    endtask
endmodule
`default_nettype wire

// *** test/tb_sdram_command_bank_state.sv ***
// self-checking bench for the sdram command decoder and bank tracker
`timescale 1ns/10ps
`default_nettype none
module tb_sdram_command_bank_state;
    import sdram_cmd_pkg::*;
    //------------------------------------------------------------------
    // signals
    //------------------------------------------------------------------
    // strobe codes: cs_n, ras_n, cas_n, we_n
    localparam logic [3:0] S_OPEN = 4'h3, S_CLOSE = 4'h2, S_WR = 4'h4;
    localparam logic [3:0] S_MODE = 4'h0, S_REF = 4'h1, S_STOP = 4'h6;
    localparam logic [3:0] S_NOP = 4'h7, S_DES = 4'hf;
    localparam logic [2:0] BLC [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    logic        clock = 1'b0;   // 200 MHz
    logic        rst = 1'b1;     // synchronous reset
    cmd_pins_t   pins;           // driven by the controller model
    cmd_t        cmd_q;          // decoded command
    logic [3:0]  bank_active_q;  // open flags
    logic [43:0] open_rows_q;    // latched rows
    pstate_t     pstate_q;       // power state
    logic        burst_q;        // burst running
    logic [10:0] mode_q;         // mode value
    wr_req_t     wr_q;           // write pulse
    logic        refresh_q;      // refresh pulse
    int          failures = 0;   // mismatches
    int          n_tests = 0;    // comparisons
    int          cycles = 0;     // hang guard
    initial begin
        forever #2.5 clock = ~clock;
    end
    sdram_ctrl_model #(.GAP(2)) u_ctrl (.clock(clock), .pins(pins));
    sdram_command_bank_state u_dut (
        .clock(clock), .rst(rst), .pins(pins), .cmd_q(cmd_q),
        .bank_active_q(bank_active_q), .open_rows_q(open_rows_q),
        .pstate_q(pstate_q), .burst_q(burst_q), .mode_q(mode_q),
        .wr_q(wr_q), .refresh_q(refresh_q));
    //------------------------------------------------------------------
    // helpers
    //------------------------------------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // with a gap of two the model returns on the falling edge after the
    // answer edge, while cmd_q and the one-cycle pulses still stand
    task automatic cmd(input logic [3:0] s, input logic k, input logic [1:0] b,
                       input logic [10:0] a, input logic [3:0] m);
        u_ctrl.send(s, k, b, a, m);
    endtask
    task automatic test_done();
        if (failures == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // a hang counts as a mismatch and ends the run
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures = failures + 1;
            test_done();
        end
    end
    //------------------------------------------------------------------
    // scenarios
    //------------------------------------------------------------------
    task automatic t_open();
        int b;
        for (b = 0; b < 4; b++) begin
            cmd(S_OPEN, 1'b1, b[1:0], 11'h400 | 11'(b), 4'h0);
            check(bank_active_q[b], 1'b1);
            check(open_rows_q[b*11 +: 11], 11'h400 | 11'(b));
            check(cmd_q, CMD_OPEN_ROW);
        end
        // second activate to an open bank must not move its row
        cmd(S_OPEN, 1'b1, 2'h0, 11'h155, 4'h0);
        check(open_rows_q[10:0], 11'h400);
    endtask
    task automatic t_write();
        cmd(S_WR, 1'b1, 2'h2, 11'h0ab, 4'h5);
        check(wr_q, {1'b1, 2'h2, 11'h402, 8'hab, 4'ha});
        cmd(S_WR, 1'b1, 2'h1, 11'h0cd, 4'h0);
        check(wr_q, {1'b1, 2'h1, 11'h401, 8'hcd, 4'hf});
        // bit 10 set asks for auto precharge of bank 3
        cmd(S_WR, 1'b1, 2'h3, 11'h412, 4'h0);
        check(bank_active_q, 4'h7);
    endtask
    task automatic t_close();
        cmd(S_CLOSE, 1'b1, 2'h1, 11'h3ff, 4'h0);
        check(bank_active_q, 4'h5);
        cmd(S_CLOSE, 1'b1, 2'h1, 11'h400, 4'h0);
        check(bank_active_q, 4'h0);
        cmd(S_CLOSE, 1'b1, 2'h0, 11'h400, 4'h0);
        check(cmd_q, CMD_CLOSE_ALL);
        // all idle now, so a leaked mode set would show in mode_q
        cmd(4'h8, 1'b1, 2'h0, 11'h7ff, 4'h0);
        check(cmd_q, CMD_DESELECT);
        check(mode_q, 11'h000);
    endtask
    task automatic t_mode();
        cmd(S_MODE, 1'b1, 2'h0, 11'h033, 4'h0);
        check(mode_q, 11'h033);
        cmd(S_OPEN, 1'b1, 2'h0, 11'h001, 4'h0);
        cmd(S_MODE, 1'b1, 2'h0, 11'h011, 4'h0);
        check(mode_q, 11'h033);
        cmd(S_REF, 1'b1, 2'h0, 11'h000, 4'h0);
        check(refresh_q, 1'b0);
        cmd(S_CLOSE, 1'b1, 2'h0, 11'h400, 4'h0);
    endtask
    task automatic t_refresh();
        cmd(S_REF, 1'b1, 2'h0, 11'h000, 4'h0);
        check(refresh_q, 1'b1);
        @(posedge clock);
        #1;
        check(refresh_q, 1'b0);
        cmd(S_REF, 1'b0, 2'h0, 11'h000, 4'h0);
        check(pstate_q, PS_SELF);
        cmd(S_DES, 1'b1, 2'h0, 11'h000, 4'h0);
        check(pstate_q, PS_RUN);
    endtask
    task automatic t_power();
        cmd(S_NOP, 1'b0, 2'h0, 11'h000, 4'h0);
        check(pstate_q, PS_PDN);
        cmd(S_OPEN, 1'b0, 2'h0, 11'h000, 4'h0);
        check(bank_active_q, 4'h0);
        cmd(S_NOP, 1'b1, 2'h0, 11'h000, 4'h0);
        check(pstate_q, PS_RUN);
    endtask
    task automatic t_suspend();
        cmd(S_OPEN, 1'b1, 2'h1, 11'h7ff, 4'h0);
        // a live strobe with clock enable falling suspends; a nop here
        // would select power-down instead
        cmd(S_STOP, 1'b0, 2'h0, 11'h000, 4'h0);
        check(pstate_q, PS_HOLD);
        cmd(S_OPEN, 1'b0, 2'h2, 11'h000, 4'h0);
        check(bank_active_q, 4'h2);
        // exit with live strobes: only the wake is taken
        cmd(S_OPEN, 1'b1, 2'h2, 11'h000, 4'h0);
        check(pstate_q, PS_RUN);
        check(bank_active_q, 4'h2);
    endtask
    task automatic t_burst();
        int i;
        // auto precharge closes the bank yet the burst still runs
        cmd(S_WR, 1'b1, 2'h1, 11'h410, 4'h0);
        check(burst_q, 1'b1);
        cmd(S_NOP, 1'b0, 2'h0, 11'h000, 4'h0);
        check(pstate_q, PS_HOLD);
        cmd(S_NOP, 1'b1, 2'h0, 11'h000, 4'h0);
        for (i = 0; i < 5; i++) begin
            cmd(S_CLOSE, 1'b1, 2'h0, 11'h400, 4'h0);
            cmd(S_MODE, 1'b1, 2'h0, {8'h04, BLC[i]}, 4'h0);
            cmd(S_OPEN, 1'b1, 2'h0, 11'h00f, 4'h0);
            cmd(S_WR, 1'b1, 2'h0, 11'h000, 4'h0);
            // every length but one beat is still running here
            check(burst_q, BLC[i] != 3'h0);
            cmd(S_STOP, 1'b1, 2'h0, 11'h000, 4'h0);
            check(burst_q, 1'b0);
        end
    endtask
    initial begin
        repeat (4) @(negedge clock);
        rst = 1'b0;
        t_open();
        t_write();
        t_close();
        t_mode();
        t_refresh();
        t_power();
        t_suspend();
        t_burst();
        test_done();
    end
endmodule
`default_nettype wire
